// File: rtl/km_pkg.sv
// constants, id lists and types shared by the keyboard/mouse switch control logic
// assumes one 50 MHz clock and a synchronous active-low reset everywhere
`default_nettype none

package km_pkg;

  // ************************************************************
  // sizes
  // ************************************************************
  localparam int NUM_HOSTS = 4;
  localparam int NUM_PERIPH = 2;
  localparam int ID_W = 32;
  localparam int DATA_W = 8;
  localparam int FIFO_DEPTH = 32;
  localparam int PORT_KBD = 0;
  localparam int PORT_MOUSE = 1;
  localparam int SEL_RESET_IDX = 0;

  // ************************************************************
  // accepted device class and interface protocols
  // ************************************************************
  localparam logic [7:0] CLASS_HID = 8'h03;
  localparam logic [7:0] PROTO_KBD = 8'h01;
  localparam logic [7:0] PROTO_MOUSE = 8'h02;

  // ************************************************************
  // fixed filter lists, vendor:product; values are arbitrary
  // ************************************************************
  localparam int DENY_N = 2;
  localparam logic [ID_W-1:0] DENY_LIST [DENY_N] = '{32'h1234_0bad, 32'h1234_0c0d};
  localparam int ALLOW_N = 3;
  localparam logic [ID_W-1:0] ALLOW_LIST [ALLOW_N] =
    '{32'h1234_0001, 32'h1234_0002, 32'h1234_0bad};

  // ************************************************************
  // timing
  // ************************************************************
  localparam int CLK_HZ = 50_000_000;
  localparam int REJECT_IND_MS = 250;
  localparam int REJECT_IND_CYCLES = REJECT_IND_MS * (CLK_HZ / 1000);

  typedef enum logic [1:0] {
    ST_SELFTEST,
    ST_RUN,
    ST_FAIL
  } mode_e;

endpackage

`default_nettype wire

// File: rtl/km_fifo.sv
// synchronous fifo with valid/ready on both sides and a flush input
// assumes flush may stay high for many cycles; the owning block holds it outside normal mode
`default_nettype none

module km_fifo #(
  parameter int W = 9,
  parameter int DEPTH = 32
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // purge
  input wire logic flush,
  // fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  // drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);

  localparam int AW = $clog2(DEPTH);

  logic [W-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;
  logic push;
  logic pop;

  assign in_ready = (count != (AW+1)'(DEPTH));
  assign out_valid = (count != '0);
  assign out_data = mem[rd_ptr];
  assign push = in_valid && in_ready && !flush;
  assign pop = out_valid && out_ready && !flush;

  // ************************************************************
  // storage; volatile only, cleared pointers make old words unreachable
  // ************************************************************
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n || flush) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
      end
      count <= count + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

endmodule

`default_nettype wire

// File: rtl/km_dev_filter.sv
// fixed deny/allow filter for an enumerating peripheral
// assumes id, class and protocol are stable while checked
`default_nettype none

module km_dev_filter
  import km_pkg::*;
(
  // clock and reset, for checks only
  input wire logic clk,
  input wire logic rst_n,
  // enumeration data
  input wire logic port,
  input wire logic [ID_W-1:0] dev_id,
  input wire logic [7:0] dev_class,
  input wire logic [7:0] dev_proto,
  // verdict
  output logic ok
);

  logic [DENY_N-1:0] deny_vec;
  logic [ALLOW_N-1:0] allow_vec;
  logic deny_hit;
  logic allow_hit;
  logic proto_ok;

  for (genvar i = 0; i < DENY_N; i++) begin : g_deny
    assign deny_vec[i] = (dev_id == DENY_LIST[i]);
  end
  for (genvar i = 0; i < ALLOW_N; i++) begin : g_allow
    assign allow_vec[i] = (dev_id == ALLOW_LIST[i]);
  end

  assign deny_hit = |deny_vec;
  assign allow_hit = |allow_vec;
  // only hid keyboard on the keyboard port, hid mouse on the mouse port
  assign proto_ok = (dev_class == CLASS_HID) &&
    (dev_proto == ((port == 1'(PORT_MOUSE)) ? PROTO_MOUSE : PROTO_KBD));
  // deny always beats allow
  assign ok = allow_hit && !deny_hit && proto_ok;

  // ************************************************************
  // checks
  // ************************************************************
  property p_deny_wins;
    @(posedge clk) disable iff (!rst_n) deny_hit |-> !ok;
  endproperty
  a_deny_wins: assert property (p_deny_wins) else $error("denied id judged ok");

  property p_allow_needed;
    @(posedge clk) disable iff (!rst_n) ok |-> (allow_hit && !deny_hit && proto_ok);
  endproperty
  a_allow_needed: assert property (p_allow_needed) else $error("ok without allow");

endmodule

`default_nettype wire

// File: rtl/km_switch.sv
// security control of a keyboard/mouse sharing switch: selection, filter, routing
// assumes debounced button levels and enumeration results from the usb host cores
//
// Function
// - forward input only to selected host
// - no data path between hosts
// - failure state blocks all data
// - deny-listed devices are unauthorized
// - allow-listed authorized only if not denied
// - refuse unauthorized peripherals at attach
// - refuse unauthorized interface protocols
// - indicate every refusal to user
// - accept only authorized device and protocol
// - peripheral ports only usb keyboard, mouse
// - emulate keyboard and mouse toward hosts
// - reject re-enumeration as unauthorized device
// - never store input in non-volatile memory
// - purge keyboard data on every switch
// - ignore scan, host and hotkey switching
// - switch only on button or remote
// - keyboard and mouse switch together
// - data flows peripheral to host only
// - self-test failure: indicate, stop switching
// - always show selected host on buttons
`default_nettype none

module km_switch
  import km_pkg::*;
#(
  parameter int REJECT_CYCLES = REJECT_IND_CYCLES,
  parameter int DEPTH = FIFO_DEPTH
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // power-on self-test result
  input wire logic selftest_done,
  input wire logic selftest_fail,
  // user selection, one level per host
  input wire logic [NUM_HOSTS-1:0] console_btn,
  input wire logic [NUM_HOSTS-1:0] remote_btn,
  // peripheral attach and enumeration
  input wire logic [NUM_PERIPH-1:0] periph_present,
  input wire logic enum_valid,
  input wire logic enum_port,
  input wire logic [ID_W-1:0] enum_id,
  input wire logic [7:0] enum_class,
  input wire logic [7:0] enum_proto,
  // peripheral reports
  input wire logic rpt_valid,
  input wire logic rpt_port,
  input wire logic [DATA_W-1:0] rpt_data,
  output logic rpt_ready,
  // emulated keyboard/mouse toward hosts
  output logic [NUM_HOSTS-1:0] host_valid,
  output logic host_is_mouse,
  output logic [DATA_W-1:0] host_data,
  input wire logic [NUM_HOSTS-1:0] host_ready,
  // indicators
  output logic [NUM_HOSTS-1:0] sel_led,
  output logic [NUM_PERIPH-1:0] port_ok,
  output logic reject_led,
  output logic fail_led,
  output logic fail_buzzer
);

  localparam int RW = $clog2(REJECT_CYCLES + 1);
  localparam int FW = DATA_W + 1;
  localparam int CW = $clog2(DEPTH + 1);

  mode_e mode;
  logic [NUM_HOSTS-1:0] btn_prev;
  logic [NUM_HOSTS-1:0] btn_now;
  logic [NUM_HOSTS-1:0] btn_rise;
  logic single_press;
  logic switch_go;
  logic filt_ok;
  logic reject_evt;
  logic [RW-1:0] rej_cnt;
  logic [RW-1:0] next_rej_cnt;
  logic fifo_flush;
  logic fifo_in_valid;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic fifo_out_ready;
  logic [FW-1:0] fifo_out_data;
  logic host_done;
  logic take;
  logic push_rpt;
  logic pop_rpt;
  logic [CW-1:0] held;
  logic [CW-1:0] next_held;

  // ************************************************************
  // operating mode
  // ************************************************************
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      mode <= ST_SELFTEST;
    end else begin
      case (mode)
        ST_SELFTEST: begin
          if (selftest_fail) begin
            mode <= ST_FAIL;
          end else if (selftest_done) begin
            mode <= ST_RUN;
          end
        end
        ST_RUN: mode <= ST_RUN;
        // only reset, i.e. a power cycle, leaves the failure state
        ST_FAIL: mode <= ST_FAIL;
        default: mode <= ST_FAIL;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      fail_led <= 1'b0;
      fail_buzzer <= 1'b0;
    end else begin
      fail_led <= (mode == ST_FAIL);
      fail_buzzer <= (mode == ST_FAIL);
    end
  end

  // ************************************************************
  // host selection
  // ************************************************************
  // only the front buttons and wired remote exist as switch sources;
  // no host, scan timer or key sequence can reach this logic
  assign btn_now = console_btn | remote_btn;
  assign btn_rise = btn_now & ~btn_prev;
  // two hosts pressed at once is ambiguous, so it is ignored
  assign single_press = (btn_rise != '0) && ((btn_rise & (btn_rise - 1'b1)) == '0);
  assign switch_go = (mode == ST_RUN) && single_press && (btn_rise != sel_led);

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      btn_prev <= '0;
    end else begin
      btn_prev <= btn_now;
    end
  end

  // one selection register governs keyboard and mouse alike
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sel_led <= NUM_HOSTS'(1) << SEL_RESET_IDX;
    end else if (switch_go) begin
      sel_led <= btn_rise;
    end
  end

  // ************************************************************
  // peripheral authorization
  // ************************************************************
  km_dev_filter u_filter (
    .clk(clk),
    .rst_n(rst_n),
    .port(enum_port),
    .dev_id(enum_id),
    .dev_class(enum_class),
    .dev_proto(enum_proto),
    .ok(filt_ok)
  );

  assign reject_evt = enum_valid && periph_present[enum_port] && !filt_ok;

  // every enumeration, first or repeated, is judged afresh
  for (genvar g = 0; g < NUM_PERIPH; g++) begin : g_port
    always_ff @(posedge clk) begin
      if (!rst_n) begin
        port_ok[g] <= 1'b0;
      end else if (!periph_present[g]) begin
        port_ok[g] <= 1'b0;
      end else if (enum_valid && (enum_port == 1'(g))) begin
        port_ok[g] <= filt_ok;
      end
    end
  end

  // refusal indication is stretched so a person can see it
  always_comb begin
    if (reject_evt) begin
      next_rej_cnt = RW'(REJECT_CYCLES);
    end else if (rej_cnt != '0) begin
      next_rej_cnt = rej_cnt - 1'b1;
    end else begin
      next_rej_cnt = '0;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rej_cnt <= '0;
      reject_led <= 1'b0;
    end else begin
      rej_cnt <= next_rej_cnt;
      reject_led <= (next_rej_cnt != '0);
    end
  end

  // ************************************************************
  // report path, peripheral to host only
  // ************************************************************
  // reports of refused ports and all reports outside normal mode are
  // swallowed; only a full buffer ever stalls the peripherals
  assign fifo_in_valid = rpt_valid && (mode == ST_RUN) && port_ok[rpt_port];
  assign fifo_flush = switch_go || (mode != ST_RUN);
  assign push_rpt = fifo_in_valid && fifo_in_ready && !fifo_flush;
  assign pop_rpt = fifo_out_valid && fifo_out_ready && !fifo_flush;

  // occupancy is mirrored here so ready can leave a flip-flop; the price
  // is that a refused port also waits while the buffer is full
  always_comb begin
    if (fifo_flush) begin
      next_held = '0;
    end else begin
      next_held = held + CW'(push_rpt) - CW'(pop_rpt);
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      held <= '0;
      rpt_ready <= 1'b1;
    end else begin
      held <= next_held;
      rpt_ready <= (next_held != CW'(DEPTH));
    end
  end

  // volatile buffer only; there is no path to any non-volatile store
  km_fifo #(
    .W(FW),
    .DEPTH(DEPTH)
  ) u_fifo (
    .clk(clk),
    .rst_n(rst_n),
    .flush(fifo_flush),
    .in_valid(fifo_in_valid),
    .in_ready(fifo_in_ready),
    .in_data({rpt_port, rpt_data}),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_out_ready),
    .out_data(fifo_out_data)
  );

  // ************************************************************
  // host emulation stage
  // ************************************************************
  // only the ready of the host being served is looked at; nothing a
  // host drives can reach another host, and the peripherals see it only as a full buffer
  assign host_done = ((host_valid & host_ready) != '0);
  assign take = fifo_out_valid && (mode == ST_RUN) && !switch_go &&
    ((host_valid == '0) || host_done);
  assign fifo_out_ready = take;

  // the device re-issues each report as its own emulated function
  always_ff @(posedge clk) begin
    if (!rst_n || (mode != ST_RUN) || switch_go) begin
      host_valid <= '0;
      host_is_mouse <= 1'b0;
      host_data <= '0;
    end else if (take) begin
      host_valid <= sel_led;
      host_is_mouse <= fifo_out_data[DATA_W];
      host_data <= fifo_out_data[DATA_W-1:0];
    end else if (host_done) begin
      host_valid <= '0;
    end
  end

  // ************************************************************
  // checks
  // ************************************************************
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  property p_fail_blocks;
    (mode == ST_FAIL) |-> (host_valid == '0) && !fifo_in_valid;
  endproperty
  a_fail_blocks: assert property (p_fail_blocks) else $error("data in failure");

  property p_fail_latched;
    (mode == ST_FAIL) |=> (mode == ST_FAIL) [*8];
  endproperty
  a_fail_latched: assert property (p_fail_latched) else $error("failure left");

  property p_fail_shown;
    (mode == ST_FAIL) |=> fail_led && fail_buzzer;
  endproperty
  a_fail_shown: assert property (p_fail_shown) else $error("failure not shown");

  property p_route_sel;
    (host_valid != '0) |-> (host_valid == sel_led);
  endproperty
  a_route_sel: assert property (p_route_sel) else $error("unselected host");

  property p_one_host;
    $onehot0(host_valid);
  endproperty
  a_one_host: assert property (p_one_host) else $error("two hosts served");

  property p_sel_onehot;
    $onehot(sel_led);
  endproperty
  a_sel_onehot: assert property (p_sel_onehot) else $error("selection shown bad");

  property p_switch_cause;
    !$stable(sel_led) |-> $past(switch_go) && ($past(btn_rise) == sel_led);
  endproperty
  a_switch_cause: assert property (p_switch_cause) else $error("switch w/o press");

  property p_purge;
    switch_go |=> !fifo_out_valid && (host_valid == '0);
  endproperty
  a_purge: assert property (p_purge) else $error("data kept over switch");

  property p_reject_led;
    reject_evt |=> reject_led;
  endproperty
  a_reject_led: assert property (p_reject_led) else $error("refusal not shown");

  property p_refuse_kbd;
    reject_evt && (enum_port == 1'(PORT_KBD)) |=> !port_ok[PORT_KBD];
  endproperty
  a_refuse_kbd: assert property (p_refuse_kbd) else $error("bad kbd accepted");

  property p_accept_ok;
    $rose(port_ok[PORT_MOUSE]) |-> $past(filt_ok) && $past(enum_valid);
  endproperty
  a_accept_ok: assert property (p_accept_ok) else $error("mouse accepted unjudged");

  c_switch: cover property (switch_go ##1 $changed(sel_led));
  c_reject: cover property (reject_evt ##1 reject_led);
  c_deliver: cover property (take ##1 host_done);
  c_fail: cover property ($rose(fail_led));

endmodule

`default_nettype wire

// File: testbench/host_model.sv
// host-side partner: one ready per emulated host, prompt, random or stalled
// assumes the bench picks the pace; ready moves just after the rising edge
`default_nettype none

module host_model
  import km_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // pace: 0 prompt, 1 random stalls, 2 fully stalled
  input wire logic [1:0] pace,
  // switch host side
  input wire logic [NUM_HOSTS-1:0] host_valid,
  output logic [NUM_HOSTS-1:0] host_ready
);
  timeunit 1ns;
  timeprecision 1ps;

  // each host stalls on its own, so a slow host never hides behind a fast one;
  // an idle host shows ready unless pace is 2 (fully stalled), which the switch must not act on
  always @(posedge clk) begin
    #1;
    if (!rst_n || pace == 2'd2) begin
      host_ready = '0;
    end else if (pace == 2'd1) begin
      host_ready = NUM_HOSTS'($urandom) | ~host_valid;
    end else begin
      host_ready = '1;
    end
  end

endmodule

`default_nettype wire

// File: testbench/km_switch_tb.sv
// self-checking bench: selection, filter, data path, purge, failure of km_switch
// assumes host_model on the host side; peripherals and buttons are driven here
`default_nettype none
`define CHK(n, e, a) begin samples_checked++; if ((a) !== (e)) begin miscompares++; \
  $display("BAD %s exp %h got %h", n, e, a); end end

module km_switch_tb
  import km_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ps;
  // short counts keep the run small
  localparam int RC = 4;
  localparam int DP = 4;
  // id, class, proto, port, expected verdict
  localparam logic [49:0] TV [9] = '{
    {32'h1234_0001, 8'h03, 8'h01, 2'b01}, {32'h1234_0bad, 8'h03, 8'h01, 2'b00},
    {32'h1234_0002, 8'h03, 8'h02, 2'b11}, {32'h1234_0c0d, 8'h03, 8'h02, 2'b10},
    {32'h1234_0002, 8'h03, 8'h01, 2'b10}, {32'h1234_0001, 8'h08, 8'h01, 2'b00},
    {32'h5555_0001, 8'h03, 8'h01, 2'b00}, {32'h1234_0001, 8'h03, 8'h01, 2'b01},
    {32'h1234_0002, 8'h03, 8'h02, 2'b11}};

  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic sdone = 1'b0, sfail = 1'b0, evalid = 1'b0, eport = 1'b0, rvalid = 1'b0, rport = 1'b0;
  logic [3:0] cbtn = '0, rbtn = '0, host_valid, host_ready, sel_led;
  logic [1:0] present = 2'b11, pace = '0, port_ok;
  logic [31:0] eid = '0;
  logic [7:0] ecls = '0, eproto = '0, rdata = '0, host_data;
  logic rready, host_is_mouse, reject_led, fail_led, fail_buzzer;
  logic [12:0] q[$];
  logic [12:0] e;
  logic [3:0] exp_sel = 4'h1;
  logic [1:0] ok_exp = '0;
  logic run = 1'b0;
  bit took;
  int n;
  int miscompares = 0;
  int samples_checked = 0;

  initial forever #10 clk = ~clk;

  km_switch #(.REJECT_CYCLES(RC), .DEPTH(DP)) dut_u (
    .clk(clk), .rst_n(rst_n), .selftest_done(sdone), .selftest_fail(sfail),
    .console_btn(cbtn), .remote_btn(rbtn), .periph_present(present),
    .enum_valid(evalid), .enum_port(eport), .enum_id(eid), .enum_class(ecls),
    .enum_proto(eproto), .rpt_valid(rvalid), .rpt_port(rport), .rpt_data(rdata),
    .rpt_ready(rready), .host_valid(host_valid), .host_is_mouse(host_is_mouse),
    .host_data(host_data), .host_ready(host_ready), .sel_led(sel_led),
    .port_ok(port_ok), .reject_led(reject_led), .fail_led(fail_led),
    .fail_buzzer(fail_buzzer));
  host_model host_u (.clk(clk), .rst_n(rst_n), .pace(pace), .host_valid(host_valid),
    .host_ready(host_ready));

  // ************************************************************
  // tasks
  // ************************************************************
  task automatic test_done();
    $display("counts: checked %0d bad %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic hang();
    miscompares++;
    $display("BAD wait exp done got timeout");
    test_done();
  endtask

  task automatic cyc(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask

  task automatic do_reset();
    rst_n = 1'b0;
    cyc(16);
    rst_n = 1'b1;
    q.delete();
    exp_sel = 4'h1;
    ok_exp = '0;
    run = 1'b0;
    `CHK("sel_led", 4'h1, sel_led)
    `CHK("port_ok", 2'b00, port_ok)
  endtask

  task automatic press(input logic [3:0] v, input logic remote);
    if (remote) begin
      rbtn = v;
    end else begin
      cbtn = v;
    end
    cyc(2);
    if (run && $countones(v) == 1 && v != exp_sel) begin
      exp_sel = v;
      q.delete();
    end
    `CHK("sel_led", exp_sel, sel_led)
    cbtn = '0;
    rbtn = '0;
    cyc(1);
  endtask

  task automatic enm(input logic [49:0] t);
    {eid, ecls, eproto, eport} = t[49:1];
    evalid = 1'b1;
    cyc(1);
    evalid = 1'b0;
    cyc(1);
    ok_exp[t[1]] = t[0];
    `CHK("port_ok", t[0], port_ok[t[1]])
    `CHK("reject_led", !t[0], reject_led)
    cyc(RC + 4);
    `CHK("reject_led", 1'b0, reject_led)
  endtask

  // leaves valid up so bytes can go back to back
  task automatic send(input logic p, input logic [7:0] d, input int lim, output bit tk);
    tk = 0;
    rport = p;
    rdata = d;
    rvalid = 1'b1;
    for (int i = 0; i < lim && !tk; i++) begin
      @(posedge clk);
      tk = (rready === 1'b1);
    end
    #1;
    if (tk && run && ok_exp[p]) q.push_back({exp_sel, p, d});
  endtask

  task automatic drain();
    for (int i = 0; i < 400 && q.size() > 0; i++) cyc(1);
    if (q.size() > 0) hang();
  endtask

  task automatic burst(input int k);
    for (int i = 0; i < k; i++) begin
      send(1'($urandom), 8'($urandom), 200, took);
      if (!took) hang();
    end
    rvalid = 1'b0;
    drain();
  endtask

  // ************************************************************
  // output monitor
  // ************************************************************
  always @(posedge clk) begin
    if (rst_n && (host_valid & host_ready) != '0) begin
      if (q.size() == 0) begin
        miscompares++;
        $display("BAD host_data exp none got %h", host_data);
      end else begin
        e = q.pop_front();
        `CHK("host_out", e, {host_valid, host_is_mouse, host_data})
      end
    end
  end

  initial begin
    #1ms;
    hang();
  end

  initial begin
    void'($urandom(32'h76db));
    do_reset();
    // presses before the self-test ends change nothing
    press(4'h4, 1'b0);
    sdone = 1'b1;
    cyc(1);
    sdone = 1'b0;
    run = 1'b1;
    cyc(1);
    $display("test reset done");
    for (int i = 0; i < 9; i++) enm(TV[i]);
    $display("test filter done");
    pace = 2'd1;
    for (int h = 0; h < 4; h++) begin
      press(4'h1 << h, h[0]);
      burst(12);
    end
    press(4'h6, 1'b1);
    burst(6);
    $display("test routing done");
    // stalled hosts keep bytes buffered; the switch must drop them all
    pace = 2'd2;
    for (int i = 0; i < 3; i++) send(1'b0, 8'(i), 200, took);
    rvalid = 1'b0;
    press(4'h2, 1'b0);
    `CHK("host_valid", 4'h0, host_valid)
    pace = 2'd0;
    cyc(20);
    $display("test purge done");
    pace = 2'd2;
    n = 0;
    took = 1;
    while (took && n < 40) begin
      send(1'b1, 8'(n), 1, took);
      n += took;
    end
    rvalid = 1'b0;
    `CHK("fill_refused", 1'b1, n == DP + 1)
    pace = 2'd1;
    drain();
    present = 2'b01;
    cyc(2);
    ok_exp[1] = 1'b0;
    `CHK("port_ok", 2'b01, port_ok)
    burst(10);
    present = 2'b11;
    $display("test buffer done");
    do_reset();
    enm(TV[7]);
    sfail = 1'b1;
    cyc(1);
    sfail = 1'b0;
    cyc(2);
    `CHK("fail_ind", 2'b11, {fail_led, fail_buzzer})
    pace = 2'd0;
    burst(10);
    press(4'h8, 1'b0);
    sdone = 1'b1;
    cyc(1);
    sdone = 1'b0;
    burst(10);
    `CHK("fail_hold", 6'h30, {fail_led, fail_buzzer, host_valid})
    $display("test failure done");
    test_done();
  end

endmodule

`default_nettype wire
